// [core/sdr_pkg.sv]
// shared constants and types for the sigma-delta readout link
package sdr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS = 1000000;
  localparam int CONV_PERIOD_MS = 8;
  localparam int SETTLE_MS = 24;
  localparam int OSC_START_MS = 1;
  localparam int RESET_LOW_NS = 100;
  localparam int READY_GUARD_NS = 800;
  localparam int SCLK_PERIOD_NS = 160;

  // longest or exact times round down, least times round up
  localparam int CONV_CYCLES = CONV_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int OSC_START_CYCLES = OSC_START_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SETTLE_CONVS = SETTLE_MS / CONV_PERIOD_MS;
  localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_GUARD_CYCLES = READY_GUARD_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int STATUS_W = 8;
  localparam int WORD_W = RESULT_W + STATUS_W;
  localparam int IDX_W = $clog2(WORD_W + 1);
  localparam int POS_RESULT_LO = 8;
  localparam int POS_READY = 7;
  localparam int POS_ZERO = 6;
  localparam int POS_ERR = 5;
  localparam int POS_PART_HI = 4;
  localparam int POS_PART_LO = 3;
  localparam int POS_PATTERN_LO = 0;
  localparam int PATTERN_W = 3;

  // part code value is arbitrary
  localparam logic [1:0] PART_CODE = 2'h2;
  localparam logic [PATTERN_W-1:0] CHECK_PATTERN = 3'h5;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_POWERDOWN = 2'h0,
    DEV_OSC_START = 2'h1,
    DEV_SETTLE = 2'h3,
    DEV_RUN = 2'h2
  } dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'h0,
    HOST_LOW = 2'h1,
    HOST_HIGH = 2'h3,
    HOST_DONE = 2'h2
  } host_state_t;

endpackage

// [core/sdr_link_if.sv]
// two-wire readout link between converter and host
`timescale 1ns/1ps
interface sdr_link_if;
  logic sclk;
  logic powerdownResetN;
  logic dataOutReadyN;
  logic dataOutReadyNOe;
  logic dataOutReadyNLine;

  // undriven line assumed pulled high
  assign dataOutReadyNLine = dataOutReadyNOe ? dataOutReadyN : 1'b1;

  modport device (
    input sclk,
    input powerdownResetN,
    output dataOutReadyN,
    output dataOutReadyNOe
  );

  modport host (
    output sclk,
    output powerdownResetN,
    input dataOutReadyNLine,
    input dataOutReadyNOe
  );
endinterface

// [core/sdr_device.sv]
// converter end: conversion pacing, reset handling and serial shift-out
// Contract
// - new result every 8 ms
// - first result only after 24 ms settling
// - host drops one extra after unaligned step
// - every conversion loads the output register
// - powered down: clock stops, line released
// - power-down resets logic, interface, filter, modulator
// - host holds power-down low 100 ns
// - wait 1 ms oscillator start after release
// - line driven high until first valid result
// - internal reset at power-up
// - results are offset binary
// - code is scaled input ratio, 16 bits
// - line low flags waiting result
// - shift 24 bits: result then status
// - host makes serial clock, device follows
// - first status bit low on new result
// - second status bit always zero
// - error bit set for out-of-range input
// - two status bits carry part code
// - last three status bits are 101
// - line high after read, read once
// - host reads before next conversion completes
// - output changes on falling serial clock
`timescale 1ns/1ps
module sdr_device #(
  parameter int CONV_CYCLES = sdr_pkg::CONV_CYCLES,
  parameter int OSC_START_CYCLES = sdr_pkg::OSC_START_CYCLES,
  parameter int READY_GUARD_CYCLES = sdr_pkg::READY_GUARD_CYCLES,
  parameter int SETTLE_CONVS = sdr_pkg::SETTLE_CONVS
) (
  input wire logic clk,
  input wire logic sys_rst,
  sdr_link_if.device link,
  input wire logic [sdr_pkg::RESULT_W-1:0] sampleCode,
  input wire logic sampleOutOfRange,
  output logic resultLoaded,
  output logic converting
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int TIMER_W = $clog2(CONV_CYCLES > OSC_START_CYCLES ? CONV_CYCLES + 1 : OSC_START_CYCLES + 1);
  localparam int CONVS_W = $clog2(SETTLE_CONVS + 1);

  initial begin
    if (CONV_CYCLES < 4 * (READY_GUARD_CYCLES + 2)) begin
      $error("conversion period too short for ready guard");
    end
    if (OSC_START_CYCLES < 1 || SETTLE_CONVS < 1 || READY_GUARD_CYCLES < 1) begin
      $error("timing counts must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic pdMeta;
  logic pdSync;
  logic sclkMeta;
  logic sclkSync;
  logic sclkPrev;
  logic rstInt;
  logic sclkFall;
  logic sclkRise;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pdMeta <= 1'b0;
      pdSync <= 1'b0;
      sclkMeta <= 1'b1;
      sclkSync <= 1'b1;
      sclkPrev <= 1'b1;
    end else begin
      pdMeta <= link.powerdownResetN;
      pdSync <= pdMeta;
      sclkMeta <= link.sclk;
      sclkSync <= sclkMeta;
      sclkPrev <= sclkSync;
    end
  end

  // power-up reset and the pin both land here, so one path clears everything past the synchronisers
  assign rstInt = sys_rst || !pdSync;
  assign sclkFall = sclkPrev && !sclkSync;
  assign sclkRise = !sclkPrev && sclkSync;

  // ----------------------------------------------------------------
  // conversion pacing
  // ----------------------------------------------------------------
  sdr_pkg::dev_state_t state;
  logic [TIMER_W-1:0] timer;
  logic [CONVS_W-1:0] convCount;
  logic convTick;
  logic guardTick;
  logic convValid;

  assign convTick = (state == sdr_pkg::DEV_SETTLE || state == sdr_pkg::DEV_RUN)
    && timer == TIMER_W'(CONV_CYCLES - 1);
  assign guardTick = state == sdr_pkg::DEV_RUN
    && timer == TIMER_W'(CONV_CYCLES - 1 - READY_GUARD_CYCLES);
  // settling results still load; only the last one is flagged
  assign convValid = state == sdr_pkg::DEV_RUN || convCount == CONVS_W'(SETTLE_CONVS - 1);

  always_ff @(posedge clk) begin
    if (rstInt) begin
      state <= sdr_pkg::DEV_POWERDOWN;
      timer <= '0;
      convCount <= '0;
    end else begin
      case (state)
        sdr_pkg::DEV_POWERDOWN: begin
          state <= sdr_pkg::DEV_OSC_START;
          timer <= '0;
        end
        sdr_pkg::DEV_OSC_START: begin
          if (timer == TIMER_W'(OSC_START_CYCLES - 1)) begin
            state <= sdr_pkg::DEV_SETTLE;
            timer <= '0;
          end else begin
            timer <= timer + 1'b1;
          end
        end
        sdr_pkg::DEV_SETTLE: begin
          if (convTick) begin
            timer <= '0;
            if (convCount == CONVS_W'(SETTLE_CONVS - 1)) begin
              state <= sdr_pkg::DEV_RUN;
            end else begin
              convCount <= convCount + 1'b1;
            end
          end else begin
            timer <= timer + 1'b1;
          end
        end
        sdr_pkg::DEV_RUN: begin
          if (convTick) begin
            timer <= '0;
          end else begin
            timer <= timer + 1'b1;
          end
        end
        default: begin
          state <= sdr_pkg::DEV_POWERDOWN;
          timer <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output register and serial shift-out
  // ----------------------------------------------------------------
  logic [sdr_pkg::WORD_W-1:0] wordReg;
  logic [sdr_pkg::WORD_W-1:0] next_word;
  logic [sdr_pkg::IDX_W-1:0] bitIdx;
  logic avail;

  // code arrives already offset binary from the filter, 2^(N-1)*(ratio+1)
  always_comb begin
    next_word = sdr_pkg::WORD_RESET;
    next_word[sdr_pkg::WORD_W-1:sdr_pkg::POS_RESULT_LO] = sampleCode;
    next_word[sdr_pkg::POS_READY] = !convValid;
    next_word[sdr_pkg::POS_ZERO] = 1'b0;
    next_word[sdr_pkg::POS_ERR] = sampleOutOfRange;
    next_word[sdr_pkg::POS_PART_HI] = sdr_pkg::PART_CODE[1];
    next_word[sdr_pkg::POS_PART_LO] = sdr_pkg::PART_CODE[0];
    next_word[sdr_pkg::POS_PATTERN_LO +: sdr_pkg::PATTERN_W] = sdr_pkg::CHECK_PATTERN;
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      wordReg <= sdr_pkg::WORD_RESET;
      bitIdx <= '0;
      avail <= 1'b0;
      link.dataOutReadyN <= 1'b1;
      link.dataOutReadyNOe <= 1'b0;
    end else begin
      link.dataOutReadyNOe <= 1'b1;
      if (convTick) begin
        // an update restarts the interface; a read in flight is lost
        wordReg <= next_word;
        bitIdx <= '0;
        avail <= convValid;
        link.dataOutReadyN <= !convValid;
      end else if (guardTick) begin
        avail <= 1'b0;
        bitIdx <= '0;
        link.dataOutReadyN <= 1'b1;
      end else if (sclkFall && avail && bitIdx < sdr_pkg::IDX_W'(sdr_pkg::WORD_W)) begin
        link.dataOutReadyN <= wordReg[sdr_pkg::IDX_W'(sdr_pkg::WORD_W - 1) - bitIdx];
        bitIdx <= bitIdx + 1'b1;
      end else if (sclkRise && avail && bitIdx == sdr_pkg::IDX_W'(sdr_pkg::WORD_W)) begin
        avail <= 1'b0;
        link.dataOutReadyN <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // user-side status
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstInt) begin
      resultLoaded <= 1'b0;
      converting <= 1'b0;
    end else begin
      resultLoaded <= convTick;
      converting <= state == sdr_pkg::DEV_SETTLE || state == sdr_pkg::DEV_RUN;
    end
  end

endmodule

// [core/sdr_host.sv]
// host end: reset pulse, serial clock generation and word capture
`timescale 1ns/1ps
module sdr_host #(
  parameter int SCLK_HALF_CYCLES = sdr_pkg::SCLK_HALF_CYCLES,
  parameter int RESET_LOW_CYCLES = sdr_pkg::RESET_LOW_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  sdr_link_if.host link,
  input wire logic powerDownRequest,
  input wire logic unalignedStep,
  output logic [sdr_pkg::RESULT_W-1:0] result,
  output logic [sdr_pkg::STATUS_W-1:0] status,
  output logic resultValid,
  output logic patternError,
  output logic partCodeMismatch,
  output logic rangeError
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int HALF_W = $clog2(SCLK_HALF_CYCLES + 1);
  localparam int HOLD_W = $clog2(RESET_LOW_CYCLES + 1);

  // a half period must cover both synchronisers and the device's reaction
  initial begin
    if (SCLK_HALF_CYCLES < 8) begin
      $error("serial clock half period below 8 cycles");
    end
    if (RESET_LOW_CYCLES < 1) begin
      $error("reset low count must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // power-down pulse
  // ----------------------------------------------------------------
  logic [HOLD_W-1:0] pdHold;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pdHold <= HOLD_W'(RESET_LOW_CYCLES);
      link.powerdownResetN <= 1'b0;
    end else if (powerDownRequest) begin
      pdHold <= HOLD_W'(RESET_LOW_CYCLES);
      link.powerdownResetN <= 1'b0;
    end else if (pdHold != '0) begin
      pdHold <= pdHold - 1'b1;
      link.powerdownResetN <= 1'b0;
    end else begin
      link.powerdownResetN <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // line synchronisers
  // ----------------------------------------------------------------
  logic lineMeta;
  logic lineSync;
  logic oeMeta;
  logic oeSync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lineMeta <= 1'b1;
      lineSync <= 1'b1;
      oeMeta <= 1'b0;
      oeSync <= 1'b0;
    end else begin
      lineMeta <= link.dataOutReadyNLine;
      lineSync <= lineMeta;
      oeMeta <= link.dataOutReadyNOe;
      oeSync <= oeMeta;
    end
  end

  // ----------------------------------------------------------------
  // read sequencer
  // ----------------------------------------------------------------
  sdr_pkg::host_state_t state;
  logic [HALF_W-1:0] halfCnt;
  logic [sdr_pkg::IDX_W-1:0] bitCnt;
  logic [sdr_pkg::WORD_W-1:0] shiftIn;
  logic [sdr_pkg::WORD_W-1:0] next_shift;
  logic halfEnd;
  logic discardPending;
  logic publish;

  assign halfEnd = halfCnt == HALF_W'(SCLK_HALF_CYCLES - 1);
  assign next_shift = {shiftIn[sdr_pkg::WORD_W-2:0], lineSync};
  assign publish = state == sdr_pkg::HOST_HIGH && halfEnd && bitCnt == sdr_pkg::IDX_W'(sdr_pkg::WORD_W);

  always_ff @(posedge clk) begin
    if (sys_rst || !link.powerdownResetN) begin
      state <= sdr_pkg::HOST_IDLE;
      halfCnt <= '0;
      bitCnt <= '0;
      shiftIn <= '0;
      link.sclk <= 1'b1;
    end else begin
      case (state)
        sdr_pkg::HOST_IDLE: begin
          halfCnt <= '0;
          bitCnt <= '0;
          if (oeSync && !lineSync) begin
            state <= sdr_pkg::HOST_LOW;
            link.sclk <= 1'b0;
          end
        end
        sdr_pkg::HOST_LOW: begin
          halfCnt <= halfEnd ? '0 : halfCnt + 1'b1;
          if (halfEnd) begin
            shiftIn <= next_shift;
            bitCnt <= bitCnt + 1'b1;
            link.sclk <= 1'b1;
            state <= sdr_pkg::HOST_HIGH;
          end
        end
        sdr_pkg::HOST_HIGH: begin
          halfCnt <= halfEnd ? '0 : halfCnt + 1'b1;
          if (halfEnd) begin
            if (bitCnt == sdr_pkg::IDX_W'(sdr_pkg::WORD_W)) begin
              state <= sdr_pkg::HOST_DONE;
            end else begin
              link.sclk <= 1'b0;
              state <= sdr_pkg::HOST_LOW;
            end
          end
        end
        sdr_pkg::HOST_DONE: begin
          if (lineSync) begin
            state <= sdr_pkg::HOST_IDLE;
          end
        end
        default: begin
          state <= sdr_pkg::HOST_IDLE;
          link.sclk <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      discardPending <= 1'b0;
    end else if (unalignedStep) begin
      discardPending <= 1'b1;
    end else if (publish && !shiftIn[sdr_pkg::POS_READY]) begin
      discardPending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result <= '0;
      status <= '0;
      resultValid <= 1'b0;
      patternError <= 1'b0;
      partCodeMismatch <= 1'b0;
      rangeError <= 1'b0;
    end else begin
      resultValid <= publish && !shiftIn[sdr_pkg::POS_READY] && !discardPending;
      if (publish) begin
        result <= shiftIn[sdr_pkg::WORD_W-1:sdr_pkg::POS_RESULT_LO];
        status <= shiftIn[sdr_pkg::STATUS_W-1:0];
        patternError <= shiftIn[sdr_pkg::POS_PATTERN_LO +: sdr_pkg::PATTERN_W] != sdr_pkg::CHECK_PATTERN;
        partCodeMismatch <= shiftIn[sdr_pkg::POS_PART_HI:sdr_pkg::POS_PART_LO] != sdr_pkg::PART_CODE;
        rangeError <= shiftIn[sdr_pkg::POS_ERR];
      end
    end
  end

endmodule

// [test/sdr_link_monitor.sv]
// link checker: timing and framing on the two-wire readout link
`timescale 1ns/1ps
module sdr_link_monitor #(
  parameter int CONV_CYCLES = sdr_pkg::CONV_CYCLES,
  parameter int OSC_START_CYCLES = sdr_pkg::OSC_START_CYCLES,
  parameter int SETTLE_CONVS = sdr_pkg::SETTLE_CONVS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic powerdownResetN,
  input wire logic dataOutReadyN,
  input wire logic dataOutReadyNOe,
  input wire logic dataOutReadyNLine
);
  // ----------------------------------------------------------
  // helper state
  // ----------------------------------------------------------
  localparam int FIRST = OSC_START_CYCLES + SETTLE_CONVS * CONV_CYCLES;
  localparam int LOW_MIN = sdr_pkg::RESET_LOW_CYCLES;
  int gap, upTime, rises, hiRun;
  logic armed, lastLine, lastSclk, lineFell, readyFell, sclkRose;
  assign lineFell = lastLine && !dataOutReadyNLine;
  // a fall means a new result only while no word is in flight
  assign readyFell = lineFell && sclk && rises == 0;
  assign sclkRose = sclk && !lastSclk;
  always_ff @(posedge clk) begin
    lastLine <= dataOutReadyNLine;
    lastSclk <= sclk;
    gap <= readyFell ? 0 : gap + 1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || !powerdownResetN) begin
      armed <= 1'b0;
      upTime <= 0;
    end else begin
      upTime <= upTime + 1;
      if (readyFell) armed <= 1'b1;
    end
  end
  // a long high run on sclk marks the gap between words
  always_ff @(posedge clk) begin
    if (sys_rst || !sclk) hiRun <= 0;
    else if (hiRun < 15) hiRun <= hiRun + 1;
    if (sys_rst || !powerdownResetN || hiRun == 15) rises <= 0;
    else if (sclkRose) rises <= rises + 1;
  end
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_pd_release: assert property (!powerdownResetN [*6] |-> !dataOutReadyNOe)
    else $error("line still driven in power-down");
  chk_drive_high: assert property ($rose(dataOutReadyNOe) |-> dataOutReadyN [*8])
    else $error("line not high after wake-up");
  chk_settle_time: assert property (readyFell && !armed |-> upTime >= FIRST && upTime <= FIRST + 12)
    else $error("first result at wrong time");
  chk_result_rate: assert property (readyFell && armed |-> gap == CONV_CYCLES - 1)
    else $error("result spacing wrong");
  chk_word_len: assert property (hiRun == 14 |-> rises == 0 || rises == 24)
    else $error("word not 24 clocks");
  chk_read_once: assert property (hiRun == 14 && rises == 24 |-> dataOutReadyNLine [*8])
    else $error("line low again after read");
  chk_ready_low: assert property (sclkRose && rises == 16 |-> !dataOutReadyNLine)
    else $error("ready bit not low");
  chk_zero_bit: assert property (sclkRose && rises == 17 |-> !dataOutReadyNLine)
    else $error("zero bit not low");
  chk_pattern_bits: assert property (sclkRose && rises == 21 |->
    dataOutReadyNLine ##20 !dataOutReadyNLine ##20 dataOutReadyNLine)
    else $error("check pattern wrong");
  chk_no_fall_high: assert property (lineFell && sclk |-> $past(sclk, 8))
    else $error("bit changed in sclk high half");
  chk_sclk_idle: assert property (!powerdownResetN |-> sclk)
    else $error("sclk not idle high");
  // a short low pulse would leave the converter half reset
  chk_reset_width: assert property ($rose(powerdownResetN) |-> !$past(powerdownResetN, LOW_MIN))
    else $error("power-down pulse too short");
  cover property (readyFell && armed);
  cover property (hiRun == 14 && rises == 24);
  cover property (!powerdownResetN ##1 powerdownResetN);
endmodule

// [test/sigma_delta_readout_port_test.sv]
// self-checking bench: both link ends joined, plus a bench-driven second link
`timescale 1ns/1ps
module sigma_delta_readout_port_test;
  // ----------------------------------------------------------
  // set-up
  // ----------------------------------------------------------
  localparam int CONV = 1000;
  localparam int OSC = 50;
  localparam int FIRST = OSC + 3 * CONV;
  localparam logic [23:0] EXP_B = {16'hA5C3, 3'h1, sdr_pkg::PART_CODE, sdr_pkg::CHECK_PATTERN};
  logic clk, sys_rst, pdReq, step, outRange, rValid, conv, sawHigh;
  logic patErr, partBad, rangeErr, loaded, loadedB;
  logic [15:0] code, result;
  logic [7:0] status;
  logic [23:0] word;
  logic [15:0] codes [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF};
  int num_errors, n_checks, tPrev, tWord, nLoad;
  int cyc = 0;
  sdr_link_if link();
  sdr_link_if linkB();
  sdr_device #(.CONV_CYCLES(CONV), .OSC_START_CYCLES(OSC), .READY_GUARD_CYCLES(4)) i_sdr_device (
    .clk(clk), .sys_rst(sys_rst), .link(link), .sampleCode(code), .sampleOutOfRange(outRange),
    .resultLoaded(loaded), .converting(conv));
  // second device faces the bench, which plays a host that may misbehave
  sdr_device #(.CONV_CYCLES(CONV), .OSC_START_CYCLES(OSC), .READY_GUARD_CYCLES(4)) i_sdr_device_b (
    .clk(clk), .sys_rst(sys_rst), .link(linkB), .sampleCode(code), .sampleOutOfRange(outRange),
    .resultLoaded(loadedB), .converting());
  sdr_host i_sdr_host (
    .clk(clk), .sys_rst(sys_rst), .link(link), .powerDownRequest(pdReq), .unalignedStep(step),
    .result(result), .status(status), .resultValid(rValid), .patternError(patErr),
    .partCodeMismatch(partBad), .rangeError(rangeErr));
  sdr_link_monitor #(.CONV_CYCLES(CONV), .OSC_START_CYCLES(OSC), .SETTLE_CONVS(3)) i_sdr_link_monitor (
    .clk(clk), .sys_rst(sys_rst), .sclk(link.sclk), .powerdownResetN(link.powerdownResetN),
    .dataOutReadyN(link.dataOutReadyN), .dataOutReadyNOe(link.dataOutReadyNOe),
    .dataOutReadyNLine(link.dataOutReadyNLine));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // every wait is bounded; running out ends the run
  task automatic bump(input int n, input int lim);
    if (n > lim) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic wait_word;
    int n;
    n = 0;
    while (rValid !== 1'b1) begin
      tick(1);
      n++;
      if (loaded === 1'b1) nLoad++;
      bump(n, 5000);
    end
    tPrev = tWord;
    tWord = cyc;
    tick(1);
  endtask
  task automatic check_word(input logic [15:0] c, input logic e);
    chk(result, c);
    chk(status, {2'h0, e, sdr_pkg::PART_CODE, sdr_pkg::CHECK_PATTERN});
    chk({rangeErr, patErr, partBad}, {e, 2'h0});
  endtask
  task automatic bring_up;
    int t0;
    t0 = cyc;
    nLoad = 0;
    tick(60);
    chk({link.dataOutReadyNOe, link.dataOutReadyNLine}, 2'h3);
    wait_word();
    chk(nLoad, 3);
    chk(tWord - t0 >= FIRST && tWord - t0 <= FIRST + 700, 1);
    check_word(code, outRange);
  endtask
  task automatic wait_b(input logic v, input int lim);
    int n;
    n = 0;
    while (linkB.dataOutReadyNLine !== v) begin
      tick(1);
      n++;
      bump(n, lim);
    end
  endtask
  task automatic wait_load;
    int n;
    n = 0;
    sawHigh = 1'b0;
    tick(10);
    while (loadedB !== 1'b1) begin
      tick(1);
      sawHigh |= linkB.dataOutReadyNLine;
      n++;
      bump(n, 2 * CONV);
    end
    tick(4);
  endtask
  task automatic read_b(input int nb);
    word = 24'h000000;
    repeat (nb) begin
      linkB.sclk = 1'b0;
      tick(10);
      word = {word[22:0], linkB.dataOutReadyNLine};
      linkB.sclk = 1'b1;
      tick(10);
    end
  endtask
  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    num_errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    pdReq = 1'b0;
    step = 1'b0;
    outRange = 1'b0;
    code = 16'h8000;
    linkB.sclk = 1'b1;
    linkB.powerdownResetN = 1'b0;
    tick(4);
    sys_rst = 1'b0;
    chk(link.dataOutReadyNOe, 0);
    bring_up();
    foreach (codes[i]) begin
      code = codes[i];
      outRange = i[0];
      wait_word();
      chk(tWord - tPrev, CONV);
      check_word(codes[i], i[0]);
    end
    step = 1'b1;
    tick(1);
    step = 1'b0;
    wait_word();
    chk(tWord - tPrev, 2 * CONV);
    pdReq = 1'b1;
    tick(20);
    chk({link.dataOutReadyNOe, conv, link.sclk}, 3'h1);
    pdReq = 1'b0;
    code = 16'h0001;
    bring_up();
    code = 16'hA5C3;
    outRange = 1'b1;
    linkB.powerdownResetN = 1'b1;
    wait_b(1'b0, FIRST + 100);
    read_b(24);
    chk(word, EXP_B);
    tick(10);
    chk(linkB.dataOutReadyNLine, 1);
    wait_b(1'b0, CONV);
    wait_load();
    chk(sawHigh, 1);
    wait_b(1'b0, CONV);
    read_b(8);
    wait_load();
    wait_b(1'b0, CONV);
    read_b(24);
    chk(word, EXP_B);
    close_out();
  end
endmodule
